// *** design/ieic_top.sv ***
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ieic_top
   import ieic_pkg::*;
#(
   parameter int N = IEIC_CHANNELS,
   parameter int AW = 6
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [N-1:0] isolated_input,
   output logic irq
);
   typedef struct packed {
      logic [N-1:0] chanIrqEnable;
      logic [N-1:0] chanEdgeSelect;
      logic [N-1:0] chanIrqFlag;
      logic [N-1:0] inputLevel;
      logic [1:0] irqEnable;
      logic [1:0] irqStatus;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic irqOut;
   } ieic_state_t;

   ieic_state_t state_reg;
   ieic_state_t state_next;
   logic [N-1:0] hit;

   // ---------------------------------------------------------------
   // Edge detector
   // ---------------------------------------------------------------
   ieic_edge_if #(.N(N)) eif ();
   assign eif.level = isolated_input;
   assign eif.edgeSel = state_reg.chanEdgeSelect;
   assign hit = eif.hit;

   ieic_edge_detect #(.N(N)) u_detect (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .eif(eif)
   );

   // ---------------------------------------------------------------
   // Register access helpers
   // ---------------------------------------------------------------
   // Map, byte address is index times four:
   //    1  input levels, read only
   //    3  channel enables
   //    4  channel edge selects
   //    5  write ones to clear flags, read back the flags
   //    6  block interrupt enables
   //    7  block interrupt status, read only, sticky
   //    8  write ones to clear block status
   // Any index above 8, or a misaligned address, is refused with an error
   // and raises the error status bit. Writes to 1 and 7 are dropped
   // without an error, so a driver that rewrites a whole image is safe.
   function automatic logic [3:0] reg_index(input logic [AW-1:0] a);
      logic [AW-1:0] sh;
      sh = a >> IEIC_ADDR_LSB;
      return sh[3:0];
   endfunction : reg_index

   function automatic logic [31:0] widen(input logic [N-1:0] v);
      logic [31:0] w;
      w = '0;
      w[N-1:0] = v;
      return w;
   endfunction : widen

   // Sticky update: a set in the same cycle as its clear wins, so an
   // edge that lands on the clear write is still seen afterwards
   function automatic logic [N-1:0] sticky(input logic [N-1:0] cur,
         input logic [N-1:0] clrv, input logic [N-1:0] setv);
      return (cur & ~clrv) | setv;
   endfunction : sticky

   logic access;
   logic wr;
   logic rd;
   logic mapped;
   logic [3:0] idx;
   logic misaligned;
   logic [AW-IEIC_ADDR_LSB-1:0] idxFull;

   // Bus decode; the answer is registered, so one wait state always
   // Ready in the state blocks a second take while pready stands
   always_comb begin
      access = psel & penable & ~state_reg.ready;
      wr = access & pwrite;
      rd = access & ~pwrite;
      idx = reg_index(paddr);
      idxFull = paddr[AW-1:IEIC_ADDR_LSB];
      misaligned = |paddr[1:0];
      // Full index compared, so high address bits cannot alias
      mapped = ~misaligned & (idxFull <= IEIC_IDX_IRQ_CLR);
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [N-1:0] clr;
      logic [1:0] ev;
      logic [1:0] stClr;
      logic [N-1:0] newHit;
      clr = '0;
      ev = '0;
      stClr = '0;
      newHit = '0;
      state_next = state_reg;
      state_next.ready = 1'b0;
      state_next.err = 1'b0;
      state_next.inputLevel = isolated_input;
      // Read data is zero unless a mapped read fills it below
      if (access) begin
         state_next.ready = 1'b1;
         state_next.err = ~mapped;
         state_next.rdata = '0;
      end
      // -----------------------------------------------------------
      // Register writes
      // -----------------------------------------------------------
      if (wr & mapped) begin
         case (idx)
            IEIC_IDX_ENABLE: begin
               state_next.chanIrqEnable = pwdata[N-1:0];
            end
            IEIC_IDX_EDGE: begin
               state_next.chanEdgeSelect = pwdata[N-1:0];
            end
            IEIC_IDX_CLEAR: begin
               clr = pwdata[N-1:0];
            end
            IEIC_IDX_IRQ_EN: begin
               state_next.irqEnable = pwdata[1:0];
            end
            IEIC_IDX_IRQ_CLR: begin
               stClr = pwdata[1:0];
            end
            default: begin
               // Read-only or unused: write ignored
            end
         endcase
      end
      // -----------------------------------------------------------
      // Register reads
      // -----------------------------------------------------------
      if (rd & mapped) begin
         case (idx)
            IEIC_IDX_INPUT: begin
               state_next.rdata = widen(state_reg.inputLevel);
            end
            IEIC_IDX_ENABLE: begin
               state_next.rdata = widen(state_reg.chanIrqEnable);
            end
            IEIC_IDX_EDGE: begin
               state_next.rdata = widen(state_reg.chanEdgeSelect);
            end
            IEIC_IDX_CLEAR: begin
               state_next.rdata = widen(state_reg.chanIrqFlag);
            end
            IEIC_IDX_IRQ_EN: begin
               state_next.rdata = {30'h0, state_reg.irqEnable};
            end
            IEIC_IDX_IRQ_STAT: begin
               state_next.rdata = {30'h0, state_reg.irqStatus};
            end
            default: begin
               state_next.rdata = '0;
            end
         endcase
      end
      // -----------------------------------------------------------
      // Channel flags and block status
      // -----------------------------------------------------------
      // Only enabled channels latch; disabled edges are lost for good
      newHit = hit & state_reg.chanIrqEnable;
      state_next.chanIrqFlag = sticky(state_reg.chanIrqFlag, clr,
                                      newHit);
      // Block events: a channel raised, or a refused bus access
      ev[IEIC_EV_FLAG] = |newHit;
      ev[IEIC_EV_ERR] = access & ~mapped;
      state_next.irqStatus = (state_reg.irqStatus & ~stClr) | ev;
      // Level output follows status and enable of the coming cycle
      state_next.irqOut = |(state_next.irqStatus & state_next.irqEnable);
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg <= '0;
         state_reg.chanIrqEnable <= IEIC_RST_ENABLE;
         state_reg.chanEdgeSelect <= IEIC_RST_EDGE;
         state_reg.chanIrqFlag <= IEIC_RST_FLAGS;
         state_reg.irqEnable <= IEIC_RST_IRQ_EN;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from flip-flops
   assign prdata = state_reg.rdata;
   assign pready = state_reg.ready;
   assign pslverr = state_reg.err;
   assign irq = state_reg.irqOut;
endmodule : ieic_top
`default_nettype wire

// *** design/ieic_pkg.sv ***
package ieic_pkg;
   // ---------------------------------------------------------------
   // Register indices; the byte address is the index times four
   // ---------------------------------------------------------------
   localparam logic [3:0] IEIC_IDX_INPUT = 4'h1;
   localparam logic [3:0] IEIC_IDX_ENABLE = 4'h3;
   localparam logic [3:0] IEIC_IDX_EDGE = 4'h4;
   localparam logic [3:0] IEIC_IDX_CLEAR = 4'h5;
   localparam logic [3:0] IEIC_IDX_IRQ_EN = 4'h6;
   localparam logic [3:0] IEIC_IDX_IRQ_STAT = 4'h7;
   localparam logic [3:0] IEIC_IDX_IRQ_CLR = 4'h8;
   localparam int IEIC_ADDR_LSB = 2;
   localparam int IEIC_CHANNELS = 8;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] IEIC_RST_ENABLE = 8'h00;
   localparam logic [7:0] IEIC_RST_EDGE = 8'h00;
   localparam logic [7:0] IEIC_RST_FLAGS = 8'h00;
   localparam logic [1:0] IEIC_RST_IRQ_EN = 2'h0;
   // Status bit positions of the block interrupt register
   localparam int IEIC_EV_FLAG = 0;
   localparam int IEIC_EV_ERR = 1;
endpackage : ieic_pkg

// *** design/ieic_edge_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Carries the per-channel control and detection results
interface ieic_edge_if #(parameter int N = 8);
   logic [N-1:0] level;
   logic [N-1:0] edgeSel;
   logic [N-1:0] hit;
   modport detector (input level, input edgeSel, output hit);
   modport owner (output level, output edgeSel, input hit);
endinterface : ieic_edge_if
`default_nettype wire

// *** design/ieic_edge_detect.sv ***
`timescale 1ns/1ps
`default_nettype none
module ieic_edge_detect
   import ieic_pkg::*;
#(
   parameter int N = IEIC_CHANNELS
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   ieic_edge_if.detector eif
);
   typedef struct packed {
      logic [N-1:0] prevLevel;
      logic primed;
   } ieic_det_state_t;

   ieic_det_state_t state_reg;
   ieic_det_state_t state_next;

   // ---------------------------------------------------------------
   // Edge detection
   // ---------------------------------------------------------------
   // Primed guards against a false edge on the first sample after reset
   always_comb begin
      state_next = state_reg;
      state_next.prevLevel = eif.level;
      state_next.primed = 1'b1;
   end

   // Rise when select is 0, fall when 1; steady level gives nothing
   always_comb begin
      for (int i = 0; i < N; i++) begin
         if (eif.edgeSel[i]) begin
            eif.hit[i] = state_reg.primed & state_reg.prevLevel[i]
                         & ~eif.level[i];
         end else begin
            eif.hit[i] = state_reg.primed & ~state_reg.prevLevel[i]
                         & eif.level[i];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
endmodule : ieic_edge_detect
`default_nettype wire

// *** testbench/ieic_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module ieic_checker #(parameter int AW = 6) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // Bus phases
   sequence setupS; psel && !penable; endsequence
   sequence accessS; psel && penable; endsequence
   sequence badS; paddr[1:0] != 2'h0 || paddr[AW-1:2] > 8; endsequence
   a_one_wait: assert property (setupS ##1 accessS |-> !pready ##1 pready)
      else $error("pready not after one wait state");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_no_stray: assert property (!(psel && penable) |=> !pready)
      else $error("pready without access");
   a_bad_err: assert property (accessS ##0 pready ##0 badS |-> pslverr)
      else $error("unmapped access not refused");
   a_good_ok: assert property (pready && !(paddr[1:0] != 2'h0 ||
      paddr[AW-1:2] > 8) |-> !pslverr)
      else $error("mapped access refused");
   a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("refused read not zero");
   a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_rst_quiet: assert property ($fell(sys_rst) |-> !pready && !irq)
      else $error("outputs active after reset");
endmodule : ieic_checker
`default_nettype wire

// *** testbench/ieic_input_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ieic_input_model (
   input wire logic clk_sys,
   input wire logic [7:0] want,
   output logic [7:0] isolated_input
);
   // Field lines move just after an edge, as a synchronised source would
   always @(posedge clk_sys) isolated_input <= want;
endmodule : ieic_input_model
`default_nettype wire

// *** testbench/input_edge_interrupt_control_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module input_edge_interrupt_control_test;
   logic clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr, irq, er;
   logic [5:0] paddr = 6'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [7:0] want = 8'h00, isolated_input, o, n, s, e, m, x;
   int seed = 32'hca58, fails = 0, num_checks = 0, cyc = 0;
   always #5 clk_sys = ~clk_sys;
   ieic_top u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .isolated_input(isolated_input), .irq(irq));
   ieic_input_model u_src (.clk_sys(clk_sys), .want(want),
      .isolated_input(isolated_input));
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer; waits for pready, however late
   task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : apb
   // Channels whose selected transition occurred while enabled
   function automatic logic [7:0] hits(logic [7:0] a, b, sl, en);
      return en & ((~sl & ~a & b) | (sl & a & ~b));
   endfunction : hits
   // Hang guard
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         report_and_stop();
      end
   end
   // Main sequence
   initial begin
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      apb(1'b0, 6'h0c, 32'h0); chk(rd, 32'h0);
      apb(1'b0, 6'h10, 32'h0); chk(rd, 32'h0);
      apb(1'b0, 6'h14, 32'h0); chk(rd, 32'h0);
      $display("reset values done");
      apb(1'b1, 6'h18, 32'h2);
      apb(1'b0, 6'h18, 32'h0); chk(rd, 32'h2);
      apb(1'b0, 6'h24, 32'h0); chk({er, rd[30:0]}, 32'h80000000);
      apb(1'b1, 6'h15, 32'hff); chk(er, 1'b1);
      apb(1'b0, 6'h1c, 32'h0); chk(rd, 32'h2);
      repeat (3) @(posedge clk_sys);
      chk(irq, 1'b1);
      apb(1'b1, 6'h20, 32'h2);
      repeat (3) @(posedge clk_sys);
      chk(irq, 1'b0);
      apb(1'b0, 6'h1c, 32'h0); chk(rd, 32'h0);
      $display("bus error tests done");
      apb(1'b1, 6'h18, 32'h1);
      for (int i = 0; i < 40; i++) begin
         o = 8'($random(seed));
         n = 8'($random(seed));
         s = 8'($random(seed));
         e = 8'($random(seed));
         m = 8'($random(seed));
         // Corners: all enabled on rising, all enabled on falling, steady lines
         if (i < 2) s = {8{i[0]}};
         if (i < 2) e = 8'hff;
         if (i == 2) n = o;
         apb(1'b1, 6'h0c, {24'h0, e});
         apb(1'b1, 6'h10, {24'h0, s});
         apb(1'b0, 6'h0c, 32'h0); chk(rd, {24'h0, e});
         apb(1'b0, 6'h10, 32'h0); chk(rd, {24'h0, s});
         want <= o;
         repeat (3) @(posedge clk_sys);
         apb(1'b1, 6'h14, 32'hff);
         apb(1'b1, 6'h20, 32'h3);
         apb(1'b1, 6'h04, 32'hff); chk(er, 1'b0);
         apb(1'b0, 6'h04, 32'h0); chk(rd, {24'h0, o});
         want <= n;
         repeat (4) @(posedge clk_sys);
         x = hits(o, n, s, e);
         chk(irq, x != 8'h0);
         apb(1'b0, 6'h1c, 32'h0); chk(rd, {31'h0, x != 8'h0});
         apb(1'b0, 6'h14, 32'h0); chk(rd, {24'h0, x});
         apb(1'b1, 6'h14, {24'h0, m});
         apb(1'b0, 6'h14, 32'h0); chk(rd, {24'h0, x & ~m});
      end
      $display("edge tests done");
      // Mid-run reset with flags and status still pending
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      chk(irq, 1'b0);
      apb(1'b0, 6'h0c, 32'h0); chk(rd, 32'h0);
      apb(1'b0, 6'h14, 32'h0); chk(rd, 32'h0);
      apb(1'b0, 6'h1c, 32'h0); chk(rd, 32'h0);
      $display("mid-run reset done");
      report_and_stop();
   end
endmodule : input_edge_interrupt_control_test
bind ieic_top ieic_checker #(.AW(AW)) u_chk (.clk_sys(clk_sys),
   .sys_rst(sys_rst), .psel(psel), .penable(penable), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire
